// *** shared/drive_io_pkg.sv ***
// Purpose: shared constants and carriers for start decode and output select
// Assumes: one 40 MHz clock, AXI4-Lite register access
// Notes: selection codes are decimal values held in 16-bit words
package drive_io_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_PRI = 8'h00;
  localparam logic [7:0] ADDR_RLY = 8'h04;
  localparam logic [7:0] ADDR_AUX = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // ----------------------------------------
  // codes and reset values
  // ----------------------------------------
  localparam logic [15:0] PRI_RST = 16'h0000;
  localparam logic [15:0] RLY_RST = 16'h0063;
  localparam logic [15:0] AUX_RST = 16'h0050;
  localparam logic [15:0] MODE_RST = 16'h270F;
  localparam logic [15:0] CODE_NONE = 16'h270F;
  localparam logic [15:0] CODE_NEG = 16'h0064;
  localparam logic [15:0] CODE_MAX = 16'h00C7;
  localparam logic [15:0] CODE_PULSE = 16'h005D;
  localparam logic [15:0] MODE_TWO_MAX = 16'h0064;
  localparam logic [15:0] MODE_FR_MIN = 16'h03E8;
  localparam logic [15:0] MODE_FR_MAX = 16'h044C;
  localparam logic [15:0] MODE_FR_ALT = 16'h22B8;
  localparam logic [7:0] PCT_PRE = 8'h55;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam int CTRL_JOG = 0;
  localparam int CTRL_3W = 1;
  localparam int TERM_PRI = 0;
  localparam int TERM_RLY = 1;
  localparam int TERM_AUX = 2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {HOLD_IDLE, HOLD_FWD, HOLD_REV} hold_t;
  typedef struct packed {
    logic [15:0] out_freq, start_freq, set_freq, det_fwd, det_rev;
    logic [15:0] out_current, cur_level, cur_time;
    logic [15:0] out_power, zc_level, zc_time;
    logic [15:0] thermal, thermal_trip, regen_use, regen_duty;
    logic [15:0] hs_temp, hs_trip;
    logic dc_brake, stall_active, pid_mode, fb_low, fb_high, pid_fwd;
    logic fan_fault, pl_decel, pl_release, retry, fault, reset_done;
    logic safety_stop, avg_pulse;
    logic [7:0] misc;
  } status_t;
  typedef struct packed {
    logic running, at_speed_flag, stall_active_flag, freq_detect_flag;
    logic regen_brake_prealarm, thermal_prealarm, operation_ready_flag;
    logic current_detect_flag, zero_current_flag, feedback_low_flag;
    logic feedback_high_flag, pid_forward_flag, fan_fault, heatsink_prealarm;
    logic powerloss_decel_flag, retry_active_flag, fault_flag;
    logic safety_monitor, current_average_pulse;
    logic [7:0] misc;
  } flags_t;
endpackage

// *** logic/start_decode_output_select.sv ***
// Purpose: start input decode, self-hold, and output terminal routing
// Assumes: all inputs synchronous to clk_in; status comes from motor control
// Notes: terminals refresh every cycle from the selected flag
//
// Operation
// - start mode picks two-wire or start/direction decode
// - jog with jog enabled ignores three-wire stop
// - shutoff stops output, keeps self-hold
// - three terminals, reset codes 0, 99, 80
// - codes 0-99 positive, 100-199 inverted
// - relay rejects pulse codes 93 and 193
// - 9999 is no function, aux rejects it
// - running when frequency at or above start
// - running off when stopped or DC braking
// - at-speed when output reaches set frequency
// - overload alarm while stall prevention active
// - frequency detect, separate reverse threshold
// - regen pre-alarm at 85 percent duty
// - thermal pre-alarm at 85 percent trip
// - ready after reset, while startable or running
// - current detect above level beyond time
// - zero current below level beyond time
// - PID low, high and forward flags
// - fan fault flag follows fan fault
// - heatsink pre-alarm near 85 percent
// - power-loss decel flag latched until release
// - retry flag during retry processing
// - fault flag until fault reset
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module start_decode_output_select
  import drive_io_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic forward_start_input_in,
  input wire logic reverse_start_input_in,
  input wire logic stop_input_in,
  input wire logic jog_input_in,
  input wire logic output_shutoff_input_in,
  input wire status_t status_in,
  output logic run_fwd_out,
  output logic run_rev_out,
  output logic primary_oc_out,
  output logic relay_out,
  output logic aux_oc_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // true when the base code (0-99) names a routable flag
  function automatic logic base_known(input logic [15:0] b);
    case (b)
      16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0007, 16'h0008,
      16'h000B, 16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h0010,
      16'h0019, 16'h001A, 16'h002E, 16'h002F, 16'h0040, 16'h0046,
      16'h0050, 16'h0051, 16'h005A, 16'h005B, 16'h005D, 16'h005F,
      16'h0060, 16'h0062, 16'h0063: base_known = 1'b1;
      default: base_known = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] base_of(input logic [15:0] c);
    base_of = (c >= CODE_NEG) ? c - CODE_NEG : c;
  endfunction

  // permitted set per terminal
  function automatic logic code_ok(input logic [15:0] c, input int t);
    logic [15:0] b;
    b = base_of(c);
    if (c == CODE_NONE) begin
      code_ok = (t != TERM_AUX);
    end else if (c > CODE_MAX) begin
      code_ok = 1'b0;
    end else if (b == CODE_PULSE) begin
      code_ok = (t != TERM_RLY);
    end else begin
      code_ok = base_known(b);
    end
  endfunction

  // selected flag with polarity; no-function drives off
  function automatic logic term_level(input logic [15:0] c, input flags_t f);
    logic v;
    v = 1'b0;
    case (base_of(c))
      16'h0000: v = f.running;
      16'h0001: v = f.at_speed_flag;
      16'h0003: v = f.stall_active_flag;
      16'h0004: v = f.freq_detect_flag;
      16'h0007: v = f.regen_brake_prealarm;
      16'h0008: v = f.thermal_prealarm;
      16'h000B: v = f.operation_ready_flag;
      16'h000C: v = f.current_detect_flag;
      16'h000D: v = f.zero_current_flag;
      16'h000E: v = f.feedback_low_flag;
      16'h000F: v = f.feedback_high_flag;
      16'h0010: v = f.pid_forward_flag;
      16'h0019: v = f.fan_fault;
      16'h001A: v = f.heatsink_prealarm;
      16'h002E: v = f.powerloss_decel_flag;
      16'h002F: v = f.misc[0];
      16'h0040: v = f.retry_active_flag;
      16'h0046: v = f.misc[1];
      16'h0050: v = f.safety_monitor;
      16'h0051: v = f.misc[2];
      16'h005A: v = f.misc[3];
      16'h005B: v = f.misc[4];
      16'h005D: v = f.current_average_pulse;
      16'h005F: v = f.misc[5];
      16'h0060: v = f.misc[6];
      16'h0062: v = f.misc[7];
      16'h0063: v = f.fault_flag;
      default: v = 1'b0;
    endcase
    if (c == CODE_NONE || c > CODE_MAX) begin
      term_level = 1'b0;
    end else begin
      term_level = (c >= CODE_NEG) ? ~v : v;
    end
  endfunction

  // value reached pct percent of limit, without division
  function automatic logic pct_ge(input logic [15:0] v, input logic [15:0] lim);
    pct_ge = (32'(v) * 32'h0000_0064) >= (32'(lim) * 32'(PCT_PRE));
  endfunction

  // counter that saturates instead of wrapping
  function automatic logic [15:0] sat_inc(input logic [15:0] n, input logic en);
    sat_inc = !en ? 16'h0000 : (n == 16'hFFFF) ? n : n + 16'h0001;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] sel_pri, sel_rly, sel_aux, mode;
    logic [1:0] ctrl;
    hold_t hold;
    logic [15:0] cur_cnt, zc_cnt;
    logic pl_latch;
    logic run_fwd, run_rev;
    logic [2:0] term;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  flags_t fl;
  logic two_wire;
  logic fr_mode;
  logic dec_fwd;
  logic dec_rev;
  logic cmd_fwd;
  logic cmd_rev;
  logic three_wire;
  logic stop_ignored;
  logic wr_fire;
  logic [7:0] wa;
  logic [31:0] old_w;
  logic [31:0] mrg;

  // ----------------------------------------
  // start decode
  // ----------------------------------------
  // unknown mode values decode as stop in both columns
  always_comb begin
    two_wire = (st_r.mode <= MODE_TWO_MAX) || (st_r.mode == MODE_RST);
    fr_mode = ((st_r.mode >= MODE_FR_MIN) && (st_r.mode <= MODE_FR_MAX))
              || (st_r.mode == MODE_FR_ALT);
    dec_fwd = forward_start_input_in && !reverse_start_input_in
              && (two_wire || fr_mode);
    dec_rev = two_wire ? (reverse_start_input_in && !forward_start_input_in)
              : (fr_mode && forward_start_input_in && reverse_start_input_in);
    three_wire = st_r.ctrl[CTRL_3W];
    stop_ignored = jog_input_in && st_r.ctrl[CTRL_JOG];
  end

  // ----------------------------------------
  // flag generation
  // ----------------------------------------
  always_comb begin
    fl = '0;
    fl.running = (status_in.out_freq >= status_in.start_freq)
                 && (st_r.run_fwd || st_r.run_rev)
                 && !status_in.dc_brake;
    fl.at_speed_flag = (st_r.run_fwd || st_r.run_rev)
                       && (status_in.out_freq >= status_in.set_freq);
    fl.stall_active_flag = status_in.stall_active;
    // reverse threshold of zero falls back to forward one
    fl.freq_detect_flag = (st_r.run_rev && status_in.det_rev != 16'h0000)
                          ? (status_in.out_freq >= status_in.det_rev)
                          : (status_in.out_freq >= status_in.det_fwd);
    fl.regen_brake_prealarm = pct_ge(status_in.regen_use, status_in.regen_duty);
    fl.thermal_prealarm = pct_ge(status_in.thermal, status_in.thermal_trip);
    fl.operation_ready_flag = status_in.reset_done && !status_in.fault
                              && !output_shutoff_input_in;
    fl.current_detect_flag = st_r.cur_cnt > status_in.cur_time;
    fl.zero_current_flag = st_r.zc_cnt > status_in.zc_time;
    fl.feedback_low_flag = status_in.pid_mode && status_in.fb_low;
    fl.feedback_high_flag = status_in.pid_mode && status_in.fb_high;
    fl.pid_forward_flag = status_in.pid_mode && status_in.pid_fwd;
    fl.fan_fault = status_in.fan_fault;
    fl.heatsink_prealarm = pct_ge(status_in.hs_temp, status_in.hs_trip);
    fl.powerloss_decel_flag = st_r.pl_latch;
    fl.retry_active_flag = status_in.retry;
    fl.fault_flag = status_in.fault;
    fl.safety_monitor = status_in.safety_stop;
    fl.current_average_pulse = status_in.avg_pulse;
    fl.misc = status_in.misc;
  end

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  // new requests wait while a response is still pending
  assign s_axi_awready_out = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready_out = !st_r.w_got && !st_r.bvalid;
  assign s_axi_arready_out = !st_r.rvalid;
  assign s_axi_bvalid_out = st_r.bvalid;
  assign s_axi_bresp_out = st_r.bresp;
  assign s_axi_rvalid_out = st_r.rvalid;
  assign s_axi_rresp_out = st_r.rresp;
  assign s_axi_rdata_out = st_r.rdata;
  assign run_fwd_out = st_r.run_fwd;
  assign run_rev_out = st_r.run_rev;
  assign primary_oc_out = st_r.term[TERM_PRI];
  assign relay_out = st_r.term[TERM_RLY];
  assign aux_oc_out = st_r.term[TERM_AUX];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    cmd_fwd = 1'b0;
    cmd_rev = 1'b0;
    // self-hold: a start pulse latches while stop is on
    if (!three_wire) begin
      st_nxt.hold = HOLD_IDLE;
    end else if (!stop_input_in && !stop_ignored) begin
      st_nxt.hold = HOLD_IDLE;
    end else if (stop_input_in && dec_fwd) begin
      st_nxt.hold = HOLD_FWD;
    end else if (stop_input_in && dec_rev) begin
      st_nxt.hold = HOLD_REV;
    end
    case (st_r.hold)
      HOLD_FWD: cmd_fwd = 1'b1;
      HOLD_REV: cmd_rev = 1'b1;
      default: begin
        cmd_fwd = dec_fwd;
        cmd_rev = dec_rev;
      end
    endcase
    // shutoff gates the drive only; the hold survives it
    st_nxt.run_fwd = cmd_fwd && !output_shutoff_input_in;
    st_nxt.run_rev = cmd_rev && !output_shutoff_input_in;
    // detection timers
    st_nxt.cur_cnt = sat_inc(st_r.cur_cnt,
                             status_in.out_current > status_in.cur_level);
    st_nxt.zc_cnt = sat_inc(st_r.zc_cnt,
                            status_in.out_power < status_in.zc_level);
    // set wins over release in the same cycle
    if (status_in.pl_decel) begin
      st_nxt.pl_latch = 1'b1;
    end else if (status_in.pl_release) begin
      st_nxt.pl_latch = 1'b0;
    end
    // no filtering: one register stage per terminal
    st_nxt.term[TERM_PRI] = term_level(st_r.sel_pri, fl);
    st_nxt.term[TERM_RLY] = term_level(st_r.sel_rly, fl);
    st_nxt.term[TERM_AUX] = term_level(st_r.sel_aux, fl);
    // write channel capture
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = s_axi_wdata_in;
      st_nxt.w_strb = s_axi_wstrb_in;
    end
    wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    wa = {st_r.aw_addr[7:2], 2'b00};
    case (wa)
      ADDR_PRI: old_w = {16'h0000, st_r.sel_pri};
      ADDR_RLY: old_w = {16'h0000, st_r.sel_rly};
      ADDR_AUX: old_w = {16'h0000, st_r.sel_aux};
      ADDR_MODE: old_w = {16'h0000, st_r.mode};
      default: old_w = {30'h0000_0000, st_r.ctrl};
    endcase
    for (int i = 0; i < 4; i++) begin
      mrg[i*8 +: 8] = st_r.w_strb[i] ? st_r.w_data[i*8 +: 8] : old_w[i*8 +: 8];
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_ERR;
      case (wa)
        ADDR_PRI: if (code_ok(mrg[15:0], TERM_PRI)) begin
          st_nxt.sel_pri = mrg[15:0];
          st_nxt.bresp = RESP_OK;
        end
        ADDR_RLY: if (code_ok(mrg[15:0], TERM_RLY)) begin
          st_nxt.sel_rly = mrg[15:0];
          st_nxt.bresp = RESP_OK;
        end
        ADDR_AUX: if (code_ok(mrg[15:0], TERM_AUX)) begin
          st_nxt.sel_aux = mrg[15:0];
          st_nxt.bresp = RESP_OK;
        end
        ADDR_MODE: if (mrg[15:0] <= MODE_TWO_MAX || mrg[15:0] == MODE_RST
                       || mrg[15:0] == MODE_FR_ALT
                       || (mrg[15:0] >= MODE_FR_MIN && mrg[15:0] <= MODE_FR_MAX)) begin
          st_nxt.mode = mrg[15:0];
          st_nxt.bresp = RESP_OK;
        end
        ADDR_CTRL: begin
          st_nxt.ctrl = mrg[1:0];
          st_nxt.bresp = RESP_OK;
        end
        default: st_nxt.bresp = RESP_ERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid = 1'b0;
    end
    // read channel: answer one cycle after the address
    if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OK;
      case ({s_axi_araddr_in[7:2], 2'b00})
        ADDR_PRI: st_nxt.rdata = {16'h0000, st_r.sel_pri};
        ADDR_RLY: st_nxt.rdata = {16'h0000, st_r.sel_rly};
        ADDR_AUX: st_nxt.rdata = {16'h0000, st_r.sel_aux};
        ADDR_MODE: st_nxt.rdata = {16'h0000, st_r.mode};
        ADDR_CTRL: st_nxt.rdata = {30'h0000_0000, st_r.ctrl};
        ADDR_STAT: st_nxt.rdata = {24'h00_0000, st_r.pl_latch, st_r.term,
                                   st_r.hold, st_r.run_rev, st_r.run_fwd};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_ERR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
      st_r.sel_pri <= PRI_RST;
      st_r.sel_rly <= RLY_RST;
      st_r.sel_aux <= AUX_RST;
      st_r.mode <= MODE_RST;
      st_r.hold <= HOLD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // a forward press under stop, released with no reverse press behind it
  sequence s_fwd_pulse;
    (three_wire && stop_input_in && dec_fwd)
    ##1 (three_wire && stop_input_in && !forward_start_input_in && !reverse_start_input_in);
  endsequence

  a_fwdrev_both: assert property (fr_mode && st_r.hold == HOLD_IDLE
    && forward_start_input_in && reverse_start_input_in && !output_shutoff_input_in
    |=> run_rev_out && !run_fwd_out) else $error("both starts not reverse");
  a_self_hold: assert property (s_fwd_pulse |=> st_r.hold == HOLD_FWD)
    else $error("start pulse not held");
  a_jog_keeps_hold: assert property (st_r.hold != HOLD_IDLE && three_wire
    && stop_ignored |=> st_r.hold != HOLD_IDLE) else $error("jog lost hold");
  a_shutoff_hold: assert property (output_shutoff_input_in && three_wire
    && stop_input_in && st_r.hold != HOLD_IDLE
    |=> !run_fwd_out && !run_rev_out && st_r.hold != HOLD_IDLE)
    else $error("shutoff cleared hold or drove");
  a_reset_codes: assert property (!$past(reset_n_in) |-> st_r.sel_pri == PRI_RST
    && st_r.sel_rly == RLY_RST && st_r.sel_aux == AUX_RST) else $error("bad reset codes");
  a_neg_fault: assert property ($past(st_r.sel_pri) == CODE_MAX
    && $past(status_in.fault) |-> !primary_oc_out) else $error("inverted fault wrong");
  a_relay_no_pulse: assert property (st_r.sel_rly != CODE_PULSE
    && st_r.sel_rly != CODE_PULSE + CODE_NEG) else $error("pulse code on relay");
  a_aux_no_none: assert property (st_r.sel_aux != CODE_NONE)
    else $error("no-function on aux");
  a_brake_not_run: assert property ($past(st_r.sel_pri) == PRI_RST
    && $past(status_in.dc_brake) |-> !primary_oc_out) else $error("running during brake");
  a_pl_latched: assert property (st_r.pl_latch && !status_in.pl_release
    |=> st_r.pl_latch [*1]) else $error("power-loss flag dropped");
endmodule

// *** testbench/start_switch_model.sv ***
// Purpose: external start switches and shutoff contact facing the drive
// Assumes: the bench sets switch positions just after a clock edge
// Notes: contacts settle one clock after a command, like a debounced panel
`timescale 1ns/1ps
module start_switch_model (
  input wire logic clk_in,
  input wire logic [4:0] cmd_in,
  output logic fwd_out,
  output logic rev_out,
  output logic stop_out,
  output logic jog_out,
  output logic shutoff_out
);
  // one clock of contact delay keeps inputs away from the sampling edge
  always_ff @(posedge clk_in) begin
    {shutoff_out, jog_out, stop_out, rev_out, fwd_out} <= cmd_in;
  end
endmodule

// *** testbench/start_decode_output_select_tb.sv ***
// Purpose: self-checking bench for start decode and output routing
// Assumes: bus answers arrive well inside the watchdog ceiling; wstrb tied to all bytes
// Notes: switches reach the block through the switch model, two clocks in all
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %0h seen %0h", n, e, g); end end
module start_decode_output_select_tb;
  import drive_io_pkg::*;
  logic clk_in = 0, reset_n_in = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic awrdy, wrdy, bv, arrdy, rv, fwd, rev, stp, jog, shut, run_f, run_r, pri, rly, aux;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_q;
  logic [1:0] bresp, rresp;
  logic [4:0] sw = 0; // {shutoff, jog, stop, rev, fwd}
  status_t st = '0;
  int fails = 0, check_count = 0, cyc = 0;
  start_switch_model sw_m (.clk_in(clk_in), .cmd_in(sw), .fwd_out(fwd), .rev_out(rev),
    .stop_out(stp), .jog_out(jog), .shutoff_out(shut));
  start_decode_output_select dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(brdy),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arrdy),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrdy),
    .forward_start_input_in(fwd), .reverse_start_input_in(rev), .stop_input_in(stp),
    .jog_input_in(jog), .output_shutoff_input_in(shut), .status_in(st),
    .run_fwd_out(run_f), .run_rev_out(run_r), .primary_oc_out(pri), .relay_out(rly), .aux_oc_out(aux));
  // ----------------------------------------
  // clock, watchdog and bus tasks
  // ----------------------------------------
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // ceiling far above the few hundred cycles the tests need
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    brdy <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk_in);
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arv && arrdy) arv <= 1'b0;
    end while (!rv);
    rrdy <= 1'b0;
    rd_q = rdata;
    `CHK("rresp", er, rresp)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    rd(ADDR_PRI, RESP_OK); `CHK("pri sel", {16'h0, PRI_RST}, rd_q)
    rd(ADDR_RLY, RESP_OK); `CHK("rly sel", 32'h0000_0063, rd_q)
    rd(ADDR_AUX, RESP_OK); `CHK("aux sel", 32'h0000_0050, rd_q)
    rd(8'h1C, RESP_ERR); `CHK("unmapped", 32'h0, rd_q)
    $display("done reset values");
  endtask
  // boundary modes of both decode families, every switch pair
  task automatic t_decode();
    logic [15:0] modes [4] = '{16'h0064, 16'h270F, 16'h044C, 16'h22B8};
    wr(ADDR_MODE, 32'h0000_0065, RESP_ERR);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, {16'h0, modes[m]}, RESP_OK);
      for (int i = 0; i < 4; i++) begin
        sw <= 5'(i);
        tick(3);
        `CHK("run fwd", (i == 1), run_f)
        `CHK("run rev", (m < 2) ? (i == 2) : (i == 3), run_r)
      end
    end
    $display("done start decode");
  endtask
  // self-hold survives shutoff and a jog-masked stop
  task automatic t_hold();
    wr(ADDR_CTRL, 32'h2, RESP_OK);
    sw <= 5'b00101;
    tick(3);
    sw <= 5'b00100;
    tick(3); `CHK("held", 1'b1, run_f)
    sw <= 5'b10100;
    tick(3); `CHK("shutoff", 1'b0, run_f)
    sw <= 5'b00100;
    tick(3); `CHK("hold kept", 1'b1, run_f)
    wr(ADDR_CTRL, 32'h3, RESP_OK);
    sw <= 5'b01000;
    tick(3); `CHK("jog stop", 1'b1, run_f)
    sw <= 5'b00000;
    // the hold drops one cycle before the command it was carrying
    tick(4); `CHK("stopped", 1'b0, run_f)
    wr(ADDR_CTRL, 32'h0, RESP_OK);
    $display("done self hold");
  endtask
  // flag selection, polarity and refused codes
  task automatic t_terms();
    st.fault <= 1'b1;
    st.safety_stop <= 1'b1;
    tick(3); `CHK("relay fault", 1'b1, rly)
    `CHK("aux safety", 1'b1, aux)
    wr(ADDR_RLY, 32'd199, RESP_OK);
    tick(3); `CHK("relay inv", 1'b0, rly)
    wr(ADDR_RLY, 32'd93, RESP_ERR);
    wr(ADDR_RLY, 32'd193, RESP_ERR);
    rd(ADDR_RLY, RESP_OK); `CHK("relay kept", 32'd199, rd_q)
    wr(ADDR_AUX, 32'd9999, RESP_ERR);
    wr(ADDR_PRI, 32'd93, RESP_OK);
    wr(ADDR_PRI, 32'd0, RESP_OK);
    st.out_freq <= 16'h0010;
    st.start_freq <= 16'h0010;
    sw <= 5'b00001;
    tick(4); `CHK("running", 1'b1, pri)
    st.dc_brake <= 1'b1;
    tick(3); `CHK("dc brake", 1'b0, pri)
    wr(ADDR_PRI, 32'd103, RESP_OK);
    st.stall_active <= 1'b1;
    tick(3); `CHK("stall inv", 1'b0, pri)
    st.stall_active <= 1'b0;
    tick(3); `CHK("stall off", 1'b1, pri)
    $display("done terminals");
  endtask
  // inverted fault on primary, power-loss latch and thermal pre-alarm on aux
  task automatic t_flags();
    wr(ADDR_PRI, 32'h0000_00C7, RESP_OK);
    tick(3); `CHK("pri inv fault", 1'b0, pri)
    wr(ADDR_AUX, 32'h0000_002E, RESP_OK);
    st.pl_decel <= 1'b1;
    st.pl_release <= 1'b1;
    tick(1);
    st.pl_decel <= 1'b0;
    st.pl_release <= 1'b0;
    tick(3); `CHK("pl set wins", 1'b1, aux)
    st.pl_release <= 1'b1;
    tick(3); `CHK("pl released", 1'b0, aux)
    st.pl_release <= 1'b0;
    wr(ADDR_AUX, 32'h0000_0008, RESP_OK);
    st.thermal <= 16'h0055;
    st.thermal_trip <= 16'h0064;
    tick(3); `CHK("thermal at 85", 1'b1, aux)
    st.thermal <= 16'h0054;
    tick(3); `CHK("thermal below 85", 1'b0, aux)
    $display("done flags");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tick(16);
    reset_n_in <= 1'b1;
    t_reset_vals();
    t_decode();
    t_hold();
    t_terms();
    t_flags();
    close_out();
  end
endmodule
